// *** octal_switch_regs.svh ***
// Purpose: Constants of the octal switch serial frame logic
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef OCTAL_SWITCH_REGS_SVH
`define OCTAL_SWITCH_REGS_SVH

// ----------------------------------------
// Check code
// ----------------------------------------
`define CRC_POLY     7'h37
`define CRC_PRESET   7'h7f
`define CRC_LEAD_BIT 1'b1

// ----------------------------------------
// Frame lengths and bit counter limit, in bits
// ----------------------------------------
`define LEN_DATA8    5'h08
`define LEN_DATA16   5'h10
`define LEN_CHECK    5'h08
`define CNT_MAX      5'h1f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_OUT_SET  8'h00
`define RST_PP_CFG   8'h00
`define RST_OL_CFG   8'h00

`endif

// *** octal_switch_pkg.sv ***
// Purpose: Types of the octal switch serial frame logic
// Assumes: Eight channels
// Notes:   Pin bundle is synchronised as one vector
package octal_switch_pkg;

  // ----------------------------------------
  // Pins from outside the system clock domain
  // ----------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       serial_select;
    logic       frame16_select;
    logic       config_select;
    logic       force_pushpull;
    logic       global_openload;
    logic       crc_enable;
    logic       undervoltage_lockout;
    logic [7:0] overload;
    logic [7:0] thermal;
    logic [7:0] openload;
    logic [7:0] level;
  } pins_t;

  // ----------------------------------------
  // System clock domain state
  // ----------------------------------------
  typedef struct packed {
    pins_t       p1;
    pins_t       p2;
    pins_t       p3;
    pins_t       stab;
    logic        serial_q;
    logic        f16_q;
    logic        cfg_q;
    logic        crc_q;
    logic [23:0] tx_q;
    logic [7:0]  out_set_q;
    logic [7:0]  pp_cfg_q;
    logic [7:0]  ol_cfg_q;
    logic        err_pend_q;
    logic        crc_err_q;
  } sys_t;

  // ----------------------------------------
  // Link clock domain state
  // ----------------------------------------
  typedef struct packed {
    logic [23:0] rx_q;
    logic [4:0]  cnt_q;
  } link_t;

endpackage

// *** octal_switch_serial_frame_crc.sv ***
// Purpose: Serial frame, setting, configuration and check code logic
// Assumes: Analog fault and level sensing arrive as pins
// Notes:   Link logic runs on the serial clock; frame data crosses while it is quiet
`timescale 1ns/1ps

module octal_switch_serial_frame_crc #(
  parameter int CHANNELS = 8
) (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        ce_in,
  input  wire logic                        sck_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        sdi_in,
  input  wire logic                        serial_select_in,
  input  wire logic                        frame16_select_in,
  input  wire logic                        config_select_in,
  input  wire logic                        force_pushpull_in,
  input  wire logic                        global_openload_in,
  input  wire logic                        crc_enable_in,
  input  wire logic                        undervoltage_lockout_in,
  input  wire logic [7:0]                  overload_in,
  input  wire logic [7:0]                  thermal_in,
  input  wire logic [7:0]                  openload_in,
  input  wire logic [7:0]                  level_in,
  output logic      [7:0]                  channel_on_out,
  output logic      [7:0]                  pushpull_out,
  output logic      [7:0]                  openload_det_out,
  output logic                             crc_error_out,
  output logic                             sdo_out,
  output logic                             sdo_oe_out,
  output logic                             sdo_pulldown_out
);
  import octal_switch_pkg::*;
  `include "octal_switch_regs.svh"

  if (CHANNELS != 8) begin : g_chk
    $error("CHANNELS must be 8");
  end

  // ----------------------------------------
  // Check code helper
  // ----------------------------------------
  // seven-bit code
  function automatic logic [6:0] crc7(input logic [16:0] bits, input int unsigned n);
    logic [6:0] c;
    logic       fb;
    c = `CRC_PRESET;
    for (int i = 16; i >= 0; i--) begin
      if (i < n) begin
        fb = bits[i] ^ c[6];
        c  = {c[5:0], 1'b0} ^ (fb ? `CRC_POLY : 7'h00);
      end
    end
    return c;
  endfunction

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  link_t      l_q;
  link_t      l_d;
  logic       fresh_q;
  logic [4:0] idx_q;

  always_comb begin
    l_d = l_q;
    l_d.rx_q  = {l_q.rx_q[22:0], sdi_in};
    l_d.cnt_q = fresh_q ? 5'h01 : ((l_q.cnt_q == `CNT_MAX) ? l_q.cnt_q : l_q.cnt_q + 5'h01);
  end

  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Marks the first rising edge of a frame
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      idx_q <= 5'h00;
    end else begin
      idx_q <= fresh_q ? 5'h00 : l_q.cnt_q;
    end
  end

  // ----------------------------------------
  // System domain
  // ----------------------------------------
  sys_t  q;
  sys_t  d;
  pins_t pins;
  logic  cs_fall;
  logic  cs_rise;
  logic  crc_act;
  logic  frame_ok;
  logic  crc_bad;
  logic  apply;

  always_comb begin
    pins.cs_n                 = cs_n_in;
    pins.serial_select        = serial_select_in;
    pins.frame16_select       = frame16_select_in;
    pins.config_select        = config_select_in;
    pins.force_pushpull       = force_pushpull_in;
    pins.global_openload      = global_openload_in;
    pins.crc_enable           = crc_enable_in;
    pins.undervoltage_lockout = undervoltage_lockout_in;
    pins.overload             = overload_in;
    pins.thermal              = thermal_in;
    pins.openload             = openload_in;
    pins.level                = level_in;
  end

  assign cs_fall = q.stab.cs_n & ~(q.p2.cs_n & q.p3.cs_n) & ~q.p2.cs_n & ~q.p3.cs_n
                   ? 1'b1 : 1'b0;
  assign cs_rise = ~q.stab.cs_n & q.p2.cs_n & q.p3.cs_n;
  assign crc_act = q.stab.serial_select & q.stab.crc_enable;

  always_comb begin
    logic [7:0]  flt;
    logic [7:0]  lvl;
    logic [7:0]  pp;
    logic [7:0]  old;
    logic [15:0] dat;
    logic [23:0] d24;
    logic [7:0]  chk;
    logic [4:0]  len;
    logic [6:0]  c_out;
    flt      = '0;
    lvl      = '0;
    pp       = '0;
    old      = '0;
    dat      = '0;
    d24      = '0;
    chk      = '0;
    len      = '0;
    c_out    = '0;
    frame_ok = 1'b0;
    crc_bad  = 1'b0;
    apply    = 1'b0;
    d        = q;
    // Three-stage pin sampling, accepted when stages two and three agree
    d.p1   = pins;
    d.p2   = q.p1;
    d.p3   = q.p2;
    d.stab = (q.p2 & q.p3) | (q.stab & (q.p2 ^ q.p3));

    pp  = q.pp_cfg_q | {8{q.stab.force_pushpull}};
    old = ~pp & (q.ol_cfg_q | {8{q.stab.serial_select & q.stab.global_openload}});
    flt = (pp & (q.stab.overload | q.stab.thermal))
        | (~pp & (q.stab.thermal | (old & ~q.out_set_q & q.stab.openload)));
    lvl = q.stab.level;
    if (q.stab.undervoltage_lockout) begin
      flt = 8'hff;
      lvl = 8'hff;
    end

    if (cs_fall) begin
      d.serial_q = q.stab.serial_select;
      d.f16_q    = q.stab.frame16_select;
      d.cfg_q    = q.stab.config_select;
      d.crc_q    = crc_act;
      if (q.stab.frame16_select) begin
        // code over data and error bit
        c_out  = crc7({flt, lvl, q.err_pend_q}, 17);
        d.tx_q = {flt, lvl, crc_act ? {q.err_pend_q, c_out} : 8'h00};
      end else begin
        c_out  = crc7({8'h00, flt, q.err_pend_q}, 9);
        d.tx_q = {flt, crc_act ? {q.err_pend_q, c_out} : 8'h00, 8'h00};
      end
      d.err_pend_q = 1'b0;
    end

    if (cs_rise) begin
      len = q.f16_q ? `LEN_DATA16 : `LEN_DATA8;
      frame_ok = l_q.cnt_q == (q.crc_q ? len + `LEN_CHECK : len);
      d24      = q.crc_q ? {8'h00, l_q.rx_q[23:8]} : l_q.rx_q;
      chk      = l_q.rx_q[7:0];
      dat      = q.f16_q ? d24[15:0] : {8'h00, d24[7:0]};
      if (q.crc_q && frame_ok) begin
        // leading one, code over data and leading one
        if (q.f16_q) begin
          crc_bad = (chk[7] != `CRC_LEAD_BIT) || (chk[6:0] != crc7({dat, 1'b1}, 17));
        end else begin
          crc_bad = (chk[7] != `CRC_LEAD_BIT) || (chk[6:0] != crc7({8'h00, dat[7:0], 1'b1}, 9));
        end
      end
      apply = frame_ok & ~crc_bad;
      if (apply) begin
        if (q.f16_q && q.cfg_q) begin
          d.ol_cfg_q = dat[15:8];
          d.pp_cfg_q = dat[7:0];
        end else if (q.serial_q && q.f16_q) begin
          d.out_set_q = dat[15:8];
          d.pp_cfg_q  = dat[7:0];
        end else if (q.serial_q && q.cfg_q) begin
          d.pp_cfg_q = dat[7:0];
        end else if (q.serial_q) begin
          d.out_set_q = dat[7:0];
        end
      end
      if (q.crc_q && frame_ok) begin
        d.crc_err_q = crc_bad;
      end
      if (crc_bad) begin
        d.err_pend_q = 1'b1;
      end
    end
    if (!ce_in) begin
      d = q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q           <= '0;
      q.p1.cs_n   <= 1'b1;
      q.p2.cs_n   <= 1'b1;
      q.p3.cs_n   <= 1'b1;
      q.stab.cs_n <= 1'b1;
      q.out_set_q <= `RST_OUT_SET;
      q.pp_cfg_q  <= `RST_PP_CFG;
      q.ol_cfg_q  <= `RST_OL_CFG;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign channel_on_out   = q.out_set_q;
  assign pushpull_out     = q.pp_cfg_q | {8{q.stab.force_pushpull}};
  assign openload_det_out = ~pushpull_out
                          & (q.ol_cfg_q | {8{q.stab.serial_select & q.stab.global_openload}});
  assign crc_error_out    = q.crc_err_q;
  assign sdo_oe_out       = ~cs_n_in;
  assign sdo_pulldown_out = cs_n_in;
  assign sdo_out          = (idx_q < 5'h18) ? q.tx_q[5'h17 - idx_q] : 1'b0;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_force;
    q.stab.force_pushpull |-> (pushpull_out == 8'hff);
  endproperty
  a_force: assert property (p_force) else $error("force push-pull ignored");

  property p_ol_hs;
    (pushpull_out & openload_det_out) == 8'h00;
  endproperty
  a_ol_hs: assert property (p_ol_hs) else $error("open-load on push-pull");

  property p_err_out;
    (cs_rise && crc_bad && ce_in) |=> (crc_error_out && q.err_pend_q);
  endproperty
  a_err_out: assert property (p_err_out) else $error("error output late");

  property p_discard;
    (cs_rise && crc_bad && ce_in) |=> ($stable(channel_on_out) && $stable(q.pp_cfg_q)
                                       && $stable(q.ol_cfg_q));
  endproperty
  a_discard: assert property (p_discard) else $error("bad frame applied");

  property p_err_bit;
    (cs_fall && ce_in && crc_act && q.err_pend_q)
      |=> ((q.f16_q ? q.tx_q[7] : q.tx_q[15]) && !q.err_pend_q);
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("error bit missing");

  property p_undervoltage_lockout;
    (cs_fall && ce_in && q.stab.undervoltage_lockout && q.stab.frame16_select)
      |=> (q.tx_q[23:8] == 16'hffff);
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("lockout flags not all ones");

  property p_no_crc;
    (cs_fall && ce_in && !q.stab.serial_select) |=> (!q.crc_q && q.tx_q[7:0] == 8'h00);
  endproperty
  a_no_crc: assert property (p_no_crc) else $error("check byte outside serial");

  property p_set8;
    (cs_rise && ce_in && q.serial_q && !q.f16_q && !q.cfg_q && !q.crc_q
     && l_q.cnt_q == `LEN_DATA8) |=> (channel_on_out == $past(l_q.rx_q[7:0]));
  endproperty
  a_set8: assert property (p_set8) else $error("setting frame not applied");

  property p_sdo_off;
    cs_n_in |-> (!sdo_oe_out && sdo_pulldown_out);
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("data output driven");

endmodule // octal_switch_serial_frame_crc

// *** spi_host_model.sv ***
// Purpose: SPI controller model that runs mode 0 frames into the switch
// Assumes: Link clock period 32 ns; clock stands low between frames
// Notes:   The bench starts frames through transfer
`timescale 1ns/1ps

module spi_host_model (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in
);
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
  end

  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  task automatic transfer(input int n, input logic [23:0] tx, output logic [23:0] rx,
                          output logic oe_ok);
    rx       = '0;
    oe_ok    = 1'b1;
    cs_n_out = 1'b0;
    #250;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = tx[i];
      #16;
      sck_out = 1'b1;
      rx      = {rx[22:0], sdo_in};
      oe_ok   = oe_ok & sdo_oe_in;
      #16;
      sck_out = 1'b0;
    end
    #16;
    cs_n_out = 1'b1;
    // Released data line must not keep the last bit
    sdi_out  = ~sdi_out;
  endtask
endmodule // spi_host_model

// *** testbench.sv ***
// Purpose: Self-checking bench of the octal switch serial frame logic
// Assumes: Controller model on the link, random sense pins
// Notes:   Expected flags and check codes are worked out here
`timescale 1ns/1ps

module testbench;
  import octal_switch_pkg::*;

  logic       sys_clk_in, rst_n_in, sck, cs_n, sdi, sdo_line;
  logic       ser, f16, cfg, force_pp, gol, crc_en, uv;
  logic [7:0] ovl, thm, opl, lvl, on_out, pp_out, det_out;
  logic       cerr, sdo, sdo_oe, sdo_pd;
  logic       ce, ce_ok;
  logic [23:0] ce_rx;
  logic [7:0] m_on, m_pp, m_ol;
  logic       m_err, m_cerr;
  int         fails, compares;
  integer     seed = 32'hfb5ea548;

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // Weak pulldown pulls the shared line low when released
  assign sdo_line = sdo_oe ? sdo : ~sdo_pd;

  octal_switch_serial_frame_crc i_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(ce), .sck_in(sck),
    .cs_n_in(cs_n), .sdi_in(sdi), .serial_select_in(ser), .frame16_select_in(f16),
    .config_select_in(cfg), .force_pushpull_in(force_pp), .global_openload_in(gol),
    .crc_enable_in(crc_en), .undervoltage_lockout_in(uv), .overload_in(ovl),
    .thermal_in(thm), .openload_in(opl), .level_in(lvl), .channel_on_out(on_out),
    .pushpull_out(pp_out), .openload_det_out(det_out), .crc_error_out(cerr),
    .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sdo_pulldown_out(sdo_pd)
  );

  spi_host_model i_host (
    .sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_line), .sdo_oe_in(sdo_oe)
  );

  // ----------------------------------------
  // Expectation helpers
  // ----------------------------------------
  function automatic logic [6:0] crc7(input logic [23:0] b, input int n);
    logic [6:0] c;
    logic       fb;
    c = 7'h7f;
    for (int i = n - 1; i >= 0; i--) begin
      fb = c[6] ^ b[i];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h37 : 7'h00);
    end
    return c;
  endfunction

  function automatic logic [15:0] flags();
    logic [7:0] p, d, f;
    p = m_pp | {8{force_pp}};
    d = ~p & (m_ol | {8{ser & gol}});
    f = (p & (ovl | thm)) | (~p & (thm | (d & opl & ~m_on)));
    return uv ? 16'hffff : {f, lvl};
  endfunction

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic pins(input logic [3:0] m);
    @(posedge sys_clk_in);
    #2;
    {ser, f16, cfg, crc_en} = m;
    force_pp = ($random(seed) & 3) == 0;
    gol      = 1'($random(seed));
    uv       = ($random(seed) & 7) == 0;
    {ovl, thm, opl, lvl} = $random(seed);
    repeat (10) @(posedge sys_clk_in);
    #2;
  endtask

  task automatic frame(input logic bad, input logic badlen);
    logic [15:0] d, o;
    logic [23:0] tx, rx, ex;
    logic [6:0]  c;
    logic        acc, ca, ok;
    int          nd, n;
    acc = ser | (f16 & cfg);
    ca  = ser & crc_en;
    nd  = f16 ? 16 : 8;
    d   = 16'($random(seed));
    if (!f16) d[15:8] = 8'h00;
    o = flags();
    if (!f16) o = {8'h00, o[15:8]};
    c  = crc7({d, 1'b1}, nd + 1);
    tx = ca ? {d, 1'b1, c ^ {6'h00, bad}} : {8'h00, d};
    ex = ca ? {o, m_err, crc7({o, m_err}, nd + 1)} : {8'h00, o};
    n = nd + (ca ? 8 : 0) + (badlen ? 1 : 0);
    i_host.transfer(n, tx, rx, ok);
    chk("sdo_oe", 1, ok);
    if (acc && !badlen) chk("sdo_data", ex, rx);
    // error bit goes out once, on the next frame only
    m_err = ca && !badlen && bad;
    if (acc && !badlen) begin
      if (ca) begin
        m_cerr = bad;
      end
      if (!(ca && bad)) begin
        case ({f16, cfg})
          2'b00:   m_on = d[7:0];
          2'b01:   m_pp = d[7:0];
          2'b10:   {m_on, m_pp} = d;
          default: {m_ol, m_pp} = d;
        endcase
      end
    end
    repeat (12) @(posedge sys_clk_in);
    #2;
    chk("sdo_oe_idle", 0, sdo_oe);
    chk("sdo_pulldown", 1, sdo_pd);
    chk("channel_on", m_on, on_out);
    chk("pushpull", m_pp | {8{force_pp}}, pp_out);
    chk("openload_det", ~(m_pp | {8{force_pp}}) & (m_ol | {8{ser & gol}}), det_out);
    chk("crc_error", m_cerr, cerr);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n_in = 1'b0;
    ce       = 1'b1;
    {ser, f16, cfg, force_pp, gol, crc_en, uv} = 7'h40;
    {ovl, thm, opl, lvl} = 32'h00000000;
    {m_on, m_pp, m_ol, m_err, m_cerr} = '0;
    fails    = 0;
    compares = 0;
    repeat (3) @(posedge sys_clk_in);
    #2;
    rst_n_in = 1'b1;
    repeat (6) @(posedge sys_clk_in);
    for (int m = 0; m < 8; m++) begin
      pins({1'b1, m[2:0]});
      frame(1'b0, 1'b0);
    end
    pins(4'b0111);
    frame(1'b0, 1'b0);
    pins(4'b0101);
    frame(1'b0, 1'b0);
    pins(4'b1011);
    frame(1'b1, 1'b0);
    pins(4'b1101);
    frame(1'b1, 1'b0);
    pins(4'b1001);
    frame(1'b0, 1'b0);
    pins(4'b1000);
    frame(1'b0, 1'b1);
    pins(4'b1011);
    frame(1'b0, 1'b1);
    for (int k = 0; k < 40; k++) begin
      pins({($random(seed) & 3) != 0, 2'($random(seed)), m_err | 1'($random(seed))});
      frame(($random(seed) & 3) == 0, 1'b0);
    end
    // Clock enable low: a whole frame passes unseen
    @(posedge sys_clk_in);
    #2;
    ce = 1'b0;
    i_host.transfer(16, 24'h00a55a, ce_rx, ce_ok);
    repeat (8) @(posedge sys_clk_in);
    #2;
    ce = 1'b1;
    repeat (12) @(posedge sys_clk_in);
    #2;
    chk("ce_freeze_on", m_on, on_out);
    chk("ce_freeze_pp", m_pp | {8{force_pp}}, pp_out);
    chk("ce_freeze_cerr", m_cerr, cerr);
    @(posedge sys_clk_in);
    #2;
    rst_n_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #2;
    chk("rst_on", 0, on_out);
    chk("rst_pp", 0, pp_out);
    chk("rst_det", 0, det_out);
    chk("rst_cerr", 0, cerr);
    rst_n_in = 1'b1;
    {m_on, m_pp, m_ol, m_err, m_cerr} = '0;
    repeat (6) @(posedge sys_clk_in);
    pins(4'b1101);
    frame(1'b0, 1'b0);
    finish_test();
  end

  initial begin
    #500000;
    fails++;
    finish_test();
  end
endmodule // testbench
